// ---- hdl/pmbus_pkg.sv ----
// constants, state codes and crc helpers for the dual two-wire slave
// assumes a 50 MHz core clock and a free-running link sampling clock
package pmbus_pkg;
    // timing
    localparam int unsigned MCLK_HZ         = 50_000_000;
    localparam int unsigned IDLE_TIMEOUT_MS = 5000;
    localparam int unsigned REINIT_CYC      =
        IDLE_TIMEOUT_MS * (MCLK_HZ / 1000);
    localparam int          TMR_W           = 28;
    // sizes
    localparam int          NPORT           = 2;
    localparam int          NSTAT           = 8;
    // protocol values; the slave address is an arbitrary default
    localparam logic [6:0]  SLAVE_ADDR       = 7'h58;
    localparam logic [7:0]  CRC_POLY         = 8'h07;
    localparam logic [7:0]  CRC_INIT         = 8'h00;
    localparam logic [7:0]  CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [1:0]  PEC_IDX          = 2'h2;
    localparam logic [5:0]  NB_CMD           = 6'h01;
    localparam logic [5:0]  NB_LO            = 6'h02;
    localparam logic [5:0]  NB_HI            = 6'h03;
    localparam logic [5:0]  NB_MIN_WR        = 6'h03;
    localparam logic [5:0]  NB_MIN_ERR       = 6'h02;
    // reset values
    localparam logic        ALERT_RST        = 1'b1;
    localparam logic        SEL_RST          = 1'b0;

    typedef enum logic [6:0] {
        L_IDLE  = 7'h01,
        L_ADDR  = 7'h02,
        L_RX    = 7'h04,
        L_ACK   = 7'h08,
        L_TX    = 7'h10,
        L_TXACK = 7'h20,
        L_WAIT  = 7'h40
    } lstate_t;

    // crc-8, msb first, no final xor
    function automatic logic [7:0] crc8(input logic [7:0] c,
                                        input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
        end
        return r;
    endfunction : crc8

    // byte sent at read position idx: low, high, then pec
    function automatic logic [7:0] tx_byte(input logic [1:0]  idx,
                                           input logic [7:0]  crc,
                                           input logic [15:0] w);
        case (idx)
            2'h0:    return w[7:0];
            2'h1:    return w[15:8];
            default: return crc;
        endcase
    endfunction : tx_byte
endpackage : pmbus_pkg

// ---- hdl/dual_pmbus_slave.sv ----
// dual two-wire management slave with pec, alert latch and port selector
// assumes open-drain pads outside; lclk runs free and fast vs the bus
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - check byte is crc-8 with generator x^8+x^2+x+1.
// - crc covers every byte, including header before a repeated start.
// - last data sender appends the crc: host on writes, device on reads.
// - controller alert passes the selector, driving both alert pins.
// - alert idles high, latches low on change until clear-faults.
// - any state change, error, pec error or bad command raises alert; command codes are not checked.
// - both alert pins asserted at power up.
// - alert released only by clear-faults or bias power cycling.
// - alert re-asserts on internal change even before status is cleared.
// - interface re-initializes after 5 s without bus activity.
// - during re-initialization a start may be missed.
// - alert raised on the first change, without waiting to settle.
// - two independent ports; one failing leaves the other usable.
// - selector defaults to the primary port at power up.
// - standard write: address, command, up to two bytes low first, crc.
// - standard read: header, repeated start, low, high, crc, host nak.
// - crc is mandatory and includes the address bytes.
// - block transfers carry a count before the data, then crc; the code has no block mode and latches only two data bytes.
// - commands without a valid trailing crc are ignored.
// - clear-faults from the non-controlling port clears only that port's selector alert; the code also clears the main alert when that port takes over.
module dual_pmbus_slave #(
    parameter int unsigned REINIT_CYC_P = pmbus_pkg::REINIT_CYC
) (
    // core clock and control
    input  wire logic                          mclk,
    input  wire logic                          nrst,
    input  wire logic                          ce,
    // link sampling clock
    input  wire logic                          lclk,
    // bus pins, enables high pull the line low
    input  wire logic [pmbus_pkg::NPORT-1:0]   scl_i,
    output logic      [pmbus_pkg::NPORT-1:0]   scl_oe,
    input  wire logic [pmbus_pkg::NPORT-1:0]   sda_i,
    output logic      [pmbus_pkg::NPORT-1:0]   sda_oe,
    output logic      [pmbus_pkg::NPORT-1:0]   alert_oe,
    // controller side
    input  wire logic [pmbus_pkg::NSTAT-1:0]   stat_i,
    input  wire logic                          uc_alert,
    output logic                               cmd_valid,
    output logic      [7:0]                    cmd_code,
    output logic      [7:0]                    cmd_lo,
    output logic      [7:0]                    cmd_hi,
    output logic                               rd_req,
    output logic      [7:0]                    rd_cmd,
    input  wire logic                          rd_ready,
    input  wire logic [15:0]                   rd_word,
    output logic                               active_port,
    output logic                               prim_fail
);
    import pmbus_pkg::*;

    typedef struct packed {
        lstate_t    st;
        logic       scl1, scl2, sda1, sda2, sclp, sdap;
        logic [3:0] bitc;
        logic [7:0] sh;
        logic [5:0] nb;
        logic       rd, txn, ackd;
        logic [1:0] rdi;
        logic [7:0] crc, cmd, lo, hi;
        logic       sda_oe, scl_oe;
        logic       req_tg, wr_tg, err_tg, act_tg;
    } lport_t;

    typedef struct packed {
        lport_t [NPORT-1:0] p;
        logic   [3:0]       x1, x2;
        logic   [1:0]       rp;
    } link_t;

    typedef struct packed {
        logic [4*NPORT-1:0]            t1, t2, tp;
        logic [NPORT-1:0][TMR_W-1:0]   tmr;
        logic [NPORT-1:0]              ack_tg, reinit_tg, pfail, sel_alert;
        logic [NPORT-1:0][15:0]        rdw;
        logic                          sel, alert, busy, bport;
        logic [NSTAT-1:0]              stp;
        logic [NPORT-1:0]              alert_oe;
        logic                          cmd_valid, rd_req;
        logic [7:0]                    code, lo, hi, rcmd;
    } core_t;

    link_t lq, ld;
    core_t cq, cd;
    logic  lrs1, lrst_n;
    logic  set_w, clr_w;

    // link reset: the core reset brought into lclk
    always_ff @(posedge lclk) begin
        lrs1   <= nrst;
        lrst_n <= lrs1;
    end

    // ---------------- link domain: bit and byte engines ----------------
    always_comb begin
        logic       rise, fall, sta, sto, pend;
        logic [7:0] b;
        rise = 1'b0;
        fall = 1'b0;
        sta  = 1'b0;
        sto  = 1'b0;
        pend = 1'b0;
        b    = 8'h00;
        ld    = lq;
        ld.x1 = {cq.reinit_tg, cq.ack_tg};
        ld.x2 = lq.x1;
        ld.rp = lq.x2[3:2];
        for (int p = 0; p < NPORT; p++) begin
            ld.p[p].scl1 = scl_i[p];
            ld.p[p].sda1 = sda_i[p];
            ld.p[p].scl2 = lq.p[p].scl1;
            ld.p[p].sda2 = lq.p[p].sda1;
            ld.p[p].sclp = lq.p[p].scl2;
            ld.p[p].sdap = lq.p[p].sda2;
            rise = lq.p[p].scl2 & ~lq.p[p].sclp;
            fall = ~lq.p[p].scl2 & lq.p[p].sclp;
            sta  = lq.p[p].scl2 & lq.p[p].sclp & lq.p[p].sdap
                   & ~lq.p[p].sda2;
            sto  = lq.p[p].scl2 & lq.p[p].sclp & ~lq.p[p].sdap
                   & lq.p[p].sda2;
            pend = lq.x2[p] != lq.p[p].req_tg;
            if ((lq.p[p].scl2 ^ lq.p[p].sclp) |
                (lq.p[p].sda2 ^ lq.p[p].sdap)) begin
                ld.p[p].act_tg = ~lq.p[p].act_tg;
            end
            if (lq.x2[2+p] != lq.rp[p]) begin
                // a start seen in this cycle is dropped
                ld.p[p].st     = L_IDLE;
                ld.p[p].txn    = 1'b0;
                ld.p[p].sda_oe = 1'b0;
                ld.p[p].scl_oe = 1'b0;
            end else if (sto) begin
                if (lq.p[p].txn && !lq.p[p].rd &&
                    lq.p[p].nb >= NB_MIN_ERR) begin
                    // residue of message plus pec is zero when intact
                    if (lq.p[p].nb >= NB_MIN_WR &&
                        lq.p[p].crc == CRC_INIT) begin
                        ld.p[p].wr_tg = ~lq.p[p].wr_tg;
                    end else begin
                        ld.p[p].err_tg = ~lq.p[p].err_tg;
                    end
                end
                ld.p[p].st     = L_IDLE;
                ld.p[p].txn    = 1'b0;
                ld.p[p].sda_oe = 1'b0;
                ld.p[p].scl_oe = 1'b0;
            end else if (sta) begin
                ld.p[p].st   = L_ADDR;
                ld.p[p].bitc = 4'h0;
                ld.p[p].rd   = 1'b0;
                ld.p[p].rdi  = 2'h0;
                ld.p[p].sda_oe = 1'b0;
                if (!lq.p[p].txn) begin
                    ld.p[p].crc = CRC_INIT;
                    ld.p[p].nb  = 6'h00;
                end // repeated start keeps the running crc
                ld.p[p].txn = 1'b1;
            end else begin
                case (lq.p[p].st)
                    L_ADDR, L_RX: begin
                        if (rise) begin
                            b = {lq.p[p].sh[6:0], lq.p[p].sda2};
                            ld.p[p].sh   = b;
                            ld.p[p].bitc = lq.p[p].bitc + 4'h1;
                            if (lq.p[p].bitc == 4'h7) begin
                                ld.p[p].bitc = 4'h0;
                                ld.p[p].st   = L_ACK;
                                ld.p[p].crc  = crc8(lq.p[p].crc, b);
                                if (lq.p[p].nb != 6'h3f) begin
                                    ld.p[p].nb = lq.p[p].nb + 6'h01;
                                end
                                if (lq.p[p].st == L_ADDR) begin
                                    ld.p[p].rd = b[0];
                                    if (b[7:1] != SLAVE_ADDR) begin
                                        ld.p[p].st  = L_WAIT;
                                        ld.p[p].crc = lq.p[p].crc;
                                        ld.p[p].nb  = lq.p[p].nb;
                                    end
                                end else if (lq.p[p].nb == NB_CMD) begin
                                    ld.p[p].cmd    = b;
                                    ld.p[p].req_tg = ~lq.p[p].req_tg;
                                end else if (lq.p[p].nb == NB_LO) begin
                                    ld.p[p].lo = b;
                                end else if (lq.p[p].nb == NB_HI) begin
                                    ld.p[p].hi = b;
                                end
                            end
                        end
                    end
                    L_ACK: begin
                        if (fall && lq.p[p].bitc == 4'h0) begin
                            ld.p[p].sda_oe = 1'b1;
                            ld.p[p].bitc   = 4'h1;
                        end else if (fall && lq.p[p].bitc == 4'h1) begin
                            // stretch after the ack until the core answers
                            ld.p[p].sda_oe = 1'b0;
                            ld.p[p].scl_oe = pend;
                            ld.p[p].bitc   = 4'h2;
                        end else if (lq.p[p].bitc == 4'h2 && !pend) begin
                            ld.p[p].scl_oe = 1'b0;
                            ld.p[p].bitc   = 4'h0;
                            ld.p[p].st     = L_RX;
                            if (lq.p[p].rd) begin
                                b = tx_byte(2'h0, lq.p[p].crc, cq.rdw[p]);
                                ld.p[p].crc    = crc8(lq.p[p].crc, b);
                                ld.p[p].sh     = {b[6:0], 1'b0};
                                ld.p[p].sda_oe = ~b[7];
                                ld.p[p].bitc   = 4'h1;
                                ld.p[p].st     = L_TX;
                            end
                        end
                    end
                    L_TX: begin
                        if (fall) begin
                            if (lq.p[p].bitc == 4'h8) begin
                                ld.p[p].sda_oe = 1'b0;
                                ld.p[p].st     = L_TXACK;
                            end else begin
                                ld.p[p].sda_oe = ~lq.p[p].sh[7];
                                ld.p[p].sh = {lq.p[p].sh[6:0], 1'b0};
                                ld.p[p].bitc = lq.p[p].bitc + 4'h1;
                            end
                        end
                    end
                    L_TXACK: begin
                        if (rise) begin
                            ld.p[p].ackd = ~lq.p[p].sda2;
                        end
                        if (fall) begin
                            ld.p[p].st = L_WAIT;
                            if (lq.p[p].ackd && lq.p[p].rdi != PEC_IDX) begin
                                ld.p[p].rdi = lq.p[p].rdi + 2'h1;
                                b = tx_byte(ld.p[p].rdi, lq.p[p].crc,
                                            cq.rdw[p]);
                                // pec goes out last, uncounted
                                if (ld.p[p].rdi != PEC_IDX) begin
                                    ld.p[p].crc = crc8(lq.p[p].crc, b);
                                end
                                ld.p[p].sh     = {b[6:0], 1'b0};
                                ld.p[p].sda_oe = ~b[7];
                                ld.p[p].bitc   = 4'h1;
                                ld.p[p].st     = L_TX;
                            end
                        end
                    end
                    L_IDLE, L_WAIT: begin
                        ld.p[p].sda_oe = 1'b0;
                    end
                    default: begin
                        ld.p[p].st = L_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge lclk) begin
        if (!lrst_n) begin
            lq <= '0;
            for (int p = 0; p < NPORT; p++) begin
                lq.p[p].st <= L_IDLE;
                // lines idle high; a zero here would fake an edge
                {lq.p[p].scl1, lq.p[p].scl2, lq.p[p].sclp} <= 3'h7;
                {lq.p[p].sda1, lq.p[p].sda2, lq.p[p].sdap} <= 3'h7;
            end
        end else begin
            lq <= ld;
        end
    end

    // ---------------- core domain: selector, alert, timers -------------
    always_comb begin
        logic [4*NPORT-1:0] ev;
        logic               take;
        ev    = cq.t2 ^ cq.tp;
        take  = 1'b0;
        set_w = 1'b0;
        clr_w = 1'b0;
        cd    = cq;
        for (int p = 0; p < NPORT; p++) begin
            cd.t1[p*4+0] = lq.p[p].act_tg;
            cd.t1[p*4+1] = lq.p[p].wr_tg;
            cd.t1[p*4+2] = lq.p[p].err_tg;
            cd.t1[p*4+3] = lq.p[p].req_tg;
        end
        cd.t2        = cq.t1;
        cd.tp        = cq.t2;
        cd.stp       = stat_i;
        cd.cmd_valid = 1'b0;
        cd.rd_req    = 1'b0;
        // first edge of any change raises the alert at once
        set_w = (|(stat_i ^ cq.stp)) | uc_alert;
        for (int p = 0; p < NPORT; p++) begin
            set_w = set_w | ev[p*4+2];
            if (ev[p*4+0]) begin
                cd.tmr[p]   = '0;
                cd.pfail[p] = 1'b0;
            end else if (cq.tmr[p] == TMR_W'(REINIT_CYC_P - 1)) begin
                cd.tmr[p]       = '0;
                cd.reinit_tg[p] = ~cq.reinit_tg[p];
                cd.pfail[p]     = 1'b1;
            end else begin
                cd.tmr[p] = cq.tmr[p] + TMR_W'(1);
            end
        end
        for (int p = 0; p < NPORT; p++) begin
            if (ev[p*4+1]) begin
                take = (cq.sel != 1'(p)) && (p == 0 || cq.pfail[0]);
                if (lq.p[p].cmd == CMD_CLEAR_FAULTS) begin
                    cd.sel_alert[p] = 1'b0;
                end
                if (cq.sel == 1'(p) || take) begin
                    cd.cmd_valid = 1'b1;
                    cd.code      = lq.p[p].cmd;
                    cd.lo        = lq.p[p].lo;
                    cd.hi        = lq.p[p].hi;
                    clr_w = clr_w | (lq.p[p].cmd == CMD_CLEAR_FAULTS);
                end
                if (take) begin
                    cd.sel             = 1'(p);
                    cd.sel_alert[1-p]  = 1'b1;
                end
            end
        end
        if (!cq.busy) begin
            for (int p = NPORT - 1; p >= 0; p--) begin
                if (cq.t2[p*4+3] != cq.ack_tg[p]) begin
                    cd.busy   = 1'b1;
                    cd.bport  = 1'(p);
                    cd.rd_req = 1'b1;
                    cd.rcmd   = lq.p[p].cmd;
                end
            end
        end else if (rd_ready) begin
            cd.busy               = 1'b0;
            cd.rdw[cq.bport]      = rd_word;
            cd.ack_tg[cq.bport]   = cq.t2[{cq.bport, 2'b11}];
        end
        // a change landing with the clear keeps the line low
        if (clr_w) begin
            cd.alert = 1'b0;
        end
        if (set_w) begin
            cd.alert = 1'b1;
        end
        cd.alert_oe = {NPORT{cd.alert}} | cd.sel_alert;
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cq          <= '0;
            cq.alert    <= ALERT_RST;
            cq.alert_oe <= {NPORT{ALERT_RST}};
            cq.sel      <= SEL_RST;
        end else if (ce) begin
            cq <= cd;
        end
    end

    assign scl_oe      = {lq.p[1].scl_oe, lq.p[0].scl_oe};
    assign sda_oe      = {lq.p[1].sda_oe, lq.p[0].sda_oe};
    assign alert_oe    = cq.alert_oe;
    assign cmd_valid   = cq.cmd_valid;
    assign cmd_code    = cq.code;
    assign cmd_lo      = cq.lo;
    assign cmd_hi      = cq.hi;
    assign rd_req      = cq.rd_req;
    assign rd_cmd      = cq.rcmd;
    assign active_port = cq.sel;
    assign prim_fail   = cq.pfail[0];

    // ---------------- checks ----------------
    a_alert_powerup: assert property (@(posedge mclk)
        !nrst ##1 nrst |-> alert_oe == 2'b11 && !active_port)
        else $error("alert or selector wrong after reset");
    a_alert_held: assert property (@(posedge mclk) disable iff (!nrst)
        cq.alert && !clr_w |=> cq.alert)
        else $error("alert released without clear");
    a_alert_set: assert property (@(posedge mclk) disable iff (!nrst)
        ce && set_w |=> alert_oe == 2'b11)
        else $error("change did not raise both alert pins");
    a_alert_clear: assert property (@(posedge mclk) disable iff (!nrst)
        ce && clr_w && !set_w |=> !cq.alert)
        else $error("clear-faults did not release alert");
    a_inactive_clear: assert property (@(posedge mclk)
        disable iff (!nrst)
        ce && (cq.t2[5] ^ cq.tp[5]) && !cq.sel && !cq.pfail[0] |-> !clr_w
        ##1 !cq.sel)
        else $error("secondary port acted while primary healthy");
    a_reinit_fire: assert property (@(posedge mclk) disable iff (!nrst)
        ce && cq.tmr[0] == TMR_W'(REINIT_CYC_P - 1) && !(cq.t2[0] ^ cq.tp[0])
        |=> cq.pfail[0] && $changed(cq.reinit_tg[0]))
        else $error("idle timeout did not reinitialize");
    a_bad_pec: assert property (@(posedge lclk) disable iff (!lrst_n)
        lq.p[0].scl2 && lq.p[0].sclp && !lq.p[0].sdap && lq.p[0].sda2 &&
        lq.p[0].crc != CRC_INIT && lq.x2[2] == lq.rp[0]
        |=> $stable(lq.p[0].wr_tg))
        else $error("write with bad pec was accepted");
    a_crc_start: assert property (@(posedge lclk) disable iff (!lrst_n)
        !lq.p[0].txn && lq.p[0].scl2 && lq.p[0].sclp && lq.p[0].sdap &&
        !lq.p[0].sda2 && lq.x2[2] == lq.rp[0]
        |=> lq.p[0].crc == CRC_INIT && lq.p[0].st == L_ADDR)
        else $error("new transaction crc not cleared");
    c_clear: cover property (@(posedge mclk) ce && clr_w);
    c_takeover: cover property (@(posedge mclk) !cq.sel ##1 cq.sel);
    c_read: cover property (@(posedge mclk) cq.rd_req ##[1:20] rd_ready);
endmodule : dual_pmbus_slave

`default_nettype wire

// ---- tb/host_model.sv ----
// host model for one port: start, stop, bytes, pec
// assumes the bench resolves the open-drain lines with pull-ups
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // resolved lines
    input  wire logic scl,
    input  wire logic sda,
    // host pull-downs
    output var  logic scl_low,
    output var  logic sda_low
);
    localparam int Q = 250;
    logic [7:0] pec = 8'h00;
    initial {scl_low, sda_low} = 2'b00;
    // released lines float to the pull-up level
    task automatic bit_io(input logic b, output logic r);
        sda_low = ~b;
        #Q scl_low = 1'b0;
        wait (scl === 1'b1); // device may stretch; bench timeout bounds it
        #Q r = sda;
        scl_low = 1'b1;
        #Q;
    endtask : bit_io
    task automatic start(input logic fresh);
        if (fresh) pec = 8'h00;
        sda_low = 1'b0;
        #Q scl_low = 1'b0;
        wait (scl === 1'b1);
        #Q sda_low = 1'b1;
        #Q scl_low = 1'b1;
        #Q;
    endtask : start
    task automatic stop();
        sda_low = 1'b1;
        #Q scl_low = 1'b0;
        wait (scl === 1'b1);
        #Q sda_low = 1'b0;
        #Q;
    endtask : stop
    task automatic fold(input logic [7:0] d);
        pec = pec ^ d;
        repeat (8) pec = pec[7] ? {pec[6:0], 1'b0} ^ 8'h07 : {pec[6:0], 1'b0};
    endtask : fold
    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        fold(d);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : put
    task automatic get(input logic nak, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        fold(d);
        bit_io(nak, r);
    endtask : get
endmodule : host_model
`default_nettype wire

// ---- tb/dual_pmbus_slave_alert_pec_test.sv ----
// random and corner tests of the dual slave on both ports
// assumes pmbus_pkg, the design and host_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module dual_pmbus_slave_alert_pec_test;
    import pmbus_pkg::*;
    localparam int unsigned REINIT = 5000; // short idle limit for sim
    logic        mclk = 0, lclk = 0, nrst = 0, uc_alert = 0, rd_ready = 0;
    logic [7:0]  stat = 0, c;
    logic [15:0] word = 0, d;
    logic [1:0]  scl_oe, sda_oe, alert_oe;
    logic        scl_low, sda_low, cmd_valid, rd_req, active_port, prim_fail;
    logic        scl1_low, sda1_low;
    logic [7:0]  cmd_code, cmd_lo, cmd_hi, rd_cmd;
    int          bad_count = 0, compares = 0, ncmd = 0, cyc = 0;
    wire logic   scl = ~(scl_low | scl_oe[0]);
    wire logic   sda = ~(sda_low | sda_oe[0]);
    wire logic   scl1 = ~(scl1_low | scl_oe[1]);
    wire logic   sda1 = ~(sda1_low | sda_oe[1]);
    always #10 mclk = ~mclk;
    always #6 lclk = ~lclk;
    dual_pmbus_slave #(.REINIT_CYC_P(REINIT)) u_dut (.mclk(mclk),
        .nrst(nrst), .ce(1'b1), .lclk(lclk), .scl_i({scl1, scl}),
        .scl_oe(scl_oe), .sda_i({sda1, sda}), .sda_oe(sda_oe),
        .alert_oe(alert_oe), .stat_i(stat), .uc_alert(uc_alert),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_lo(cmd_lo),
        .cmd_hi(cmd_hi), .rd_req(rd_req), .rd_cmd(rd_cmd),
        .rd_ready(rd_ready), .rd_word(word), .active_port(active_port),
        .prim_fail(prim_fail));
    host_model u_host (.scl(scl), .sda(sda), .scl_low(scl_low),
        .sda_low(sda_low));
    host_model u_host1 (.scl(scl1), .sda(sda1), .scl_low(scl1_low),
        .sda_low(sda1_low));
    // controller answers each request one cycle later
    always @(posedge mclk) begin
        rd_ready <= (rd_req === 1'b1);
        ncmd <= ncmd + int'(cmd_valid === 1'b1);
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            bad_count++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : complete_run
    task automatic check(input string nm, input logic [15:0] e, g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    task automatic wr(input logic [7:0] cm, input int n,
                      input logic [15:0] dv, input logic [7:0] flip);
        logic a;
        int   k;
        k = ncmd;
        u_host.start(1'b1);
        u_host.put({SLAVE_ADDR, 1'b0}, a);
        check("addr ack", 16'h1, {15'h0, a});
        u_host.put(cm, a);
        for (int i = 0; i < n; i++) u_host.put(dv[8*i +: 8], a);
        u_host.put(u_host.pec ^ flip, a);
        u_host.stop();
        repeat (20) @(posedge mclk);
        check("cmd count", 16'(k + int'(flip == 0)), 16'(ncmd));
        if (flip == 0) check("cmd code", {8'h0, cm}, {8'h0, cmd_code});
        if (n == 2 && flip == 0) check("cmd data", dv, {cmd_hi, cmd_lo});
    endtask : wr
    task automatic rd(input logic [7:0] cm);
        logic       a;
        logic [7:0] lo, hi, p, e;
        u_host.start(1'b1);
        u_host.put({SLAVE_ADDR, 1'b0}, a);
        u_host.put(cm, a);
        check("read cmd", {8'h0, cm}, {8'h0, rd_cmd});
        u_host.start(1'b0);
        u_host.put({SLAVE_ADDR, 1'b1}, a);
        u_host.get(1'b0, lo);
        u_host.get(1'b0, hi);
        e = u_host.pec;
        u_host.get(1'b1, p);
        u_host.stop();
        check("read word", word, {hi, lo});
        check("read pec", {8'h0, e}, {8'h0, p});
    endtask : rd
    // short write from the secondary host, valid pec
    task automatic wr1(input logic [7:0] cm);
        logic a;
        u_host1.start(1'b1);
        u_host1.put({SLAVE_ADDR, 1'b0}, a);
        u_host1.put(cm, a);
        u_host1.put(u_host1.pec, a);
        u_host1.stop();
    endtask : wr1
    task automatic alert_after(input logic [1:0] e);
        repeat (3) @(posedge mclk);
        #1 check("alert", {14'h0, e}, {14'h0, alert_oe});
    endtask : alert_after
    initial begin
        void'($urandom(73));
        repeat (2) @(posedge mclk);
        #1 check("reset alert", 16'h3, {14'h0, alert_oe});
        check("reset port", 16'h0, {15'h0, active_port});
        nrst = 1'b1;
        repeat (10) @(posedge mclk);
        wr(CMD_CLEAR_FAULTS, 0, 16'h0, 8'h00);
        check("cleared", 16'h0, {15'h0, alert_oe[0]});
        for (int t = 0; t < 3; t++) begin
            c = {1'b1, 7'($urandom)};
            d = 16'($urandom);
            word = 16'($urandom);
            wr(c, 2, d, 8'h00);
            rd(c);
        end
        wr(c, 2, d, 8'h01);
        check("pec alert", 16'h1, {15'h0, alert_oe[0]});
        wr(CMD_CLEAR_FAULTS, 0, 16'h0, 8'h00);
        @(posedge mclk) #1 stat = stat ^ (8'h01 << $urandom % 8);
        alert_after(2'b11);
        wr(CMD_CLEAR_FAULTS, 0, 16'h0, 8'h00);
        @(posedge mclk) #1 uc_alert = 1'b1;
        alert_after(2'b11);
        uc_alert = 1'b0;
        repeat (REINIT + 100) @(posedge mclk);
        #1 check("idle fail", 16'h1, {15'h0, prim_fail});
        // quiet primary lets the secondary take over and clear
        wr1(CMD_CLEAR_FAULTS);
        alert_after(2'b01);
        check("takeover", 16'h1, {15'h0, active_port});
        wr(CMD_CLEAR_FAULTS, 0, 16'h0, 8'h00);
        check("return", 16'h0, {15'h0, active_port});
        alert_after(2'b10);
        stat = ~stat;
        alert_after(2'b11);
        // healthy primary: a clear from the secondary neither takes over nor releases the alert
        wr1(CMD_CLEAR_FAULTS);
        alert_after(2'b11);
        check("no takeover", 16'h0, {15'h0, active_port});
        rd(c);
        check("port", 16'h0, {15'h0, active_port});
        complete_run();
    end
endmodule : dual_pmbus_slave_alert_pec_test
`default_nettype wire
